// file: pcsb_pkg.sv
// pcsb_pkg.sv: constants and types for the clock generator stop/break control block.
// assumes: single 200 MHz system clock, no register bus; every control bit is a plain port.
package pcsb_pkg;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_BASE_SRC   = 1'b0;  // crystal path selected after reset
    localparam logic RST_AUTO_BW    = 1'b0;  // manual bandwidth after reset
    localparam logic RST_ACQ        = 1'b0;  // acquisition mode after reset
    localparam logic RST_LOCK       = 1'b0;  // unlocked after reset
    localparam logic RST_EVENT_FLAG = 1'b0;  // no pll event after reset
    localparam logic RST_BREAK_CLEAR_FLAG_ENABLE       = 1'b0;  // break clears blocked after reset

    // ****************************************************************
    // base source select encoding
    // ****************************************************************
    localparam logic SRC_VCO_HALF  = 1'b1;   // vco clock halved drives base clock
    localparam logic SRC_XTAL_HALF = 1'b0;   // crystal halved drives base clock

    // ****************************************************************
    // timing: one divide-by-two enable on the system clock
    // ****************************************************************
    localparam int  CLK_MHZ      = 200;
    localparam int  HALF_DIV     = 2;        // base clock is source divided by two
    localparam logic [0:0] DIV_TOP = 1'(HALF_DIV - 1);

    // ****************************************************************
    // low power state of the generator
    // ****************************************************************
    typedef enum logic [1:0] {
        PCSB_RUN     = 2'h0,                 // outputs toggling
        PCSB_STOPPED = 2'h1,                 // oscillator enable low, outputs held low
        PCSB_RESTART = 2'h3                  // enable back, crystal path starts first
    } pcsb_state_e;

endpackage : pcsb_pkg

// file: pcsb_clk_if.sv
// pcsb_clk_if.sv: carries the generator enables and sampled oscillator enable between modules.
// assumes: both modules run on the same system clock.
`timescale 1ns/1ps
interface pcsb_clk_if;
    logic osc_run;      // generator allowed to run
    logic sel_vco;      // base clock uses the vco path
    logic xtal_en;      // crystal reference enable pulse
    logic base_en;      // base clock enable pulse
    modport ctrl (output osc_run, output sel_vco, input xtal_en, input base_en);
    modport gen  (input osc_run, input sel_vco, output xtal_en, output base_en);
endinterface : pcsb_clk_if

// file: pcsb_clk_gen.sv
// pcsb_clk_gen.sv: divider producing the crystal and base clock enable pulses.
// assumes: vco_tick is a one-cycle pulse on i_clk from the pll model outside.
`timescale 1ns/1ps
module pcsb_clk_gen
    import pcsb_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // source ticks
    input  wire logic i_xtal_tick,
    input  wire logic i_vco_tick,
    // control side
    pcsb_clk_if.gen   cif
);

    // ****************************************************************
    // divide-by-two phases
    // ****************************************************************
    logic [0:0] xdiv_q;   // crystal halving phase
    logic [0:0] vdiv_q;   // vco halving phase
    logic       src_tick; // tick of the selected source

    // divider is cleared while stopped so the crystal restarts from phase zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xdiv_q <= '0;
        end else if (!cif.osc_run) begin
            xdiv_q <= '0;                          // [RQ1]
        end else if (i_xtal_tick) begin
            xdiv_q <= (xdiv_q == DIV_TOP) ? '0 : xdiv_q + 1'b1;
        end
    end

    // vco divider runs only while the vco path is chosen
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vdiv_q <= '0;
        end else if (!cif.osc_run || !cif.sel_vco) begin
            vdiv_q <= '0;
        end else if (i_vco_tick) begin
            vdiv_q <= (vdiv_q == DIV_TOP) ? '0 : vdiv_q + 1'b1;
        end
    end

    // crystal enable gated by the oscillator enable
    assign cif.xtal_en = cif.osc_run & i_xtal_tick;                 // [RQ1] [RQ13]
    assign src_tick    = cif.sel_vco ? i_vco_tick : i_xtal_tick;
    // base enable on the wrap of the selected halving divider
    assign cif.base_en = cif.osc_run & src_tick &
                         ((cif.sel_vco ? vdiv_q : xdiv_q) == DIV_TOP); // [RQ3]

endmodule // pcsb_clk_gen

// file: pcsb_top.sv
// pcsb_top.sv: stop-mode and break-state control for the pll clock generator.
// assumes: system controller, break logic and pll analogue side are outside; all on i_clk.
// Operation
// RQ1: oscillator enable low forces generator outputs low
// RQ2: stop with vco source clears base select
// RQ3: after stop, crystal halved drives base clock
// RQ4: break clear enable lets software clear flags
// RQ5: flags cleared in break stay cleared
// RQ6: without enable, break accesses keep event flag
// RQ7: auto mode sets tracking bit on tracking entry
// RQ8: auto mode sets lock bit on lock entry
// RQ9: base select one means vco, zero crystal
// RQ10: event flag sets on every lock change
// RQ11: lock reads zero in manual mode
// RQ12: tracking bit writable only in manual mode
// RQ13: outputs resume after enable, crystal path first
`timescale 1ns/1ps
module pcsb_top
    import pcsb_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // system controller and break state
    input  wire logic i_osc_enable_from_sysctl,
    input  wire logic i_break_active,
    input  wire logic i_break_clear_flag_enable_wr,
    input  wire logic i_break_clear_flag_enable_val,
    // pll control register access
    input  wire logic i_pll_control_reg_rd,
    input  wire logic i_pll_control_reg_wr,
    input  wire logic i_base_src_select_wr,
    input  wire logic i_pll_irq_enable_wr,
    input  wire logic i_pll_event_flag_clr,
    // bandwidth register access
    input  wire logic i_pll_bandwidth_reg_wr,
    input  wire logic i_auto_bw_wr,
    input  wire logic i_acq_tracking_wr,
    // analogue side indications
    input  wire logic i_xtal_tick,
    input  wire logic i_vco_tick,
    input  wire logic i_err_below_track,
    input  wire logic i_err_below_lock,
    // clock outputs
    output logic      o_crystal_ref_clock,
    output logic      o_base_clock_out,
    output logic      o_clock_gen_irq,
    // status
    output logic      o_base_src_select,
    output logic      o_pll_irq_enable,
    output logic      o_pll_event_flag,
    output logic      o_auto_bw,
    output logic      o_acq_tracking_status,
    output logic      o_lock,
    output logic      o_break_clear_flag_enable
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic osc_meta_q;     // first stage, read only by the second
    logic osc_sync_q;     // synchronised oscillator enable
    logic trk_meta_q;
    logic trk_sync_q;     // synchronised tracking tolerance met
    logic lck_meta_q;
    logic lck_sync_q;     // synchronised lock tolerance met

    // oscillator enable and analogue comparators come from outside the domain
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            trk_meta_q <= 1'b0;
            trk_sync_q <= 1'b0;
            lck_meta_q <= 1'b0;
            lck_sync_q <= 1'b0;
        end else begin
            osc_meta_q <= i_osc_enable_from_sysctl;
            osc_sync_q <= osc_meta_q;
            trk_meta_q <= i_err_below_track;
            trk_sync_q <= trk_meta_q;
            lck_meta_q <= i_err_below_lock;
            lck_sync_q <= lck_meta_q;
        end
    end

    // ****************************************************************
    // stop state machine
    // ****************************************************************
    pcsb_state_e state_q;   // current low power state
    pcsb_state_e state_d;   // next low power state
    logic        run;       // generator allowed to run

    // restart holds one cycle so the crystal path runs before anything else
    always_comb begin
        state_d = state_q;
        case (state_q)
            PCSB_RUN: begin
                if (!osc_sync_q) state_d = PCSB_STOPPED;    // [RQ1]
            end
            PCSB_STOPPED: begin
                if (osc_sync_q) state_d = PCSB_RESTART;     // [RQ13]
            end
            PCSB_RESTART: begin
                state_d = osc_sync_q ? PCSB_RUN : PCSB_STOPPED;
            end
            default: begin
                state_d = PCSB_STOPPED;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) state_q <= PCSB_STOPPED;
        else          state_q <= state_d;
    end

    assign run = (state_q != PCSB_STOPPED) && osc_sync_q;           // [RQ1]

    // ****************************************************************
    // base source select
    // ****************************************************************
    logic bcs_q;   // base source select bit

    // stop wins over a software set in the same cycle; stays clear until rewritten
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bcs_q <= RST_BASE_SRC;                                  // [RQ9]
        end else if (!osc_sync_q || state_q != PCSB_RUN) begin
            bcs_q <= SRC_XTAL_HALF;                                 // [RQ2] [RQ3] [RQ9]
        end else if (i_pll_control_reg_wr) begin
            bcs_q <= i_base_src_select_wr;                          // [RQ9]
        end
    end

    // ****************************************************************
    // divider and clock outputs
    // ****************************************************************
    pcsb_clk_if cif ();
    logic       xclk_q;  // crystal reference out
    logic       base_q;  // base clock out

    assign cif.osc_run = run;
    assign cif.sel_vco = (bcs_q == SRC_VCO_HALF);

    pcsb_clk_gen u_gen (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_xtal_tick (i_xtal_tick),
        .i_vco_tick  (i_vco_tick),
        .cif         (cif.gen)
    );

    // outputs toggle on enable pulses, forced low while stopped
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xclk_q <= 1'b0;
            base_q <= 1'b0;
        end else if (!run) begin
            xclk_q <= 1'b0;                                         // [RQ1]
            base_q <= 1'b0;                                         // [RQ1]
        end else begin
            if (cif.xtal_en) xclk_q <= ~xclk_q;                     // [RQ13]
            if (cif.base_en) base_q <= ~base_q;                     // [RQ3]
        end
    end

    // ****************************************************************
    // bandwidth control
    // ****************************************************************
    logic auto_q;     // automatic bandwidth mode
    logic acq_man_q;  // manual tracking choice, kept across auto mode
    logic acq_st_q;   // automatic tracking status
    logic lock_q;     // raw lock indicator

    // mode and manual tracking bit from software
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            auto_q    <= RST_AUTO_BW;
            acq_man_q <= RST_ACQ;
        end else if (i_pll_bandwidth_reg_wr) begin
            auto_q <= i_auto_bw_wr;
            if (!auto_q) acq_man_q <= i_acq_tracking_wr;            // [RQ12]
        end
    end

    // automatic status follows the tolerance comparators
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acq_st_q <= RST_ACQ;
            lock_q   <= RST_LOCK;
        end else if (!auto_q) begin
            acq_st_q <= RST_ACQ;
            lock_q   <= RST_LOCK;
        end else begin
            acq_st_q <= trk_sync_q;                                 // [RQ7]
            lock_q   <= lck_sync_q;                                 // [RQ8]
        end
    end

    // ****************************************************************
    // event flag, irq enable and break protection
    // ****************************************************************
    logic break_clear_flag_enable_q;     // break clear flag enable
    logic pie_q;      // pll irq enable
    logic pll_event_flag_q;     // pll event flag
    logic lock_chg;   // lock indicator changed
    logic sw_clr;     // permitted software clear of the flag

    // break clear enable lives with the break logic; modelled here as a plain bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)                          break_clear_flag_enable_q <= RST_BREAK_CLEAR_FLAG_ENABLE;  // [RQ6]
        else if (i_break_clear_flag_enable_wr) break_clear_flag_enable_q <= i_break_clear_flag_enable_val;
    end

    // irq enable is an ordinary control register bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)                  pie_q <= 1'b0;
        else if (i_pll_control_reg_wr) pie_q <= i_pll_irq_enable_wr;
    end

    assign lock_chg = auto_q && (lck_sync_q != lock_q);             // [RQ10]
    // a read acknowledge step clears too; outside break always, in break only when enabled
    assign sw_clr   = (i_pll_event_flag_clr || i_pll_control_reg_rd) &&
                      (!i_break_active || break_clear_flag_enable_q);                  // [RQ4] [RQ6]

    // set beats clear; no restore on break exit since nothing is saved
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)      pll_event_flag_q <= RST_EVENT_FLAG;
        else if (!auto_q)  pll_event_flag_q <= 1'b0;                          // [RQ10]
        else if (lock_chg) pll_event_flag_q <= 1'b1;                          // [RQ10]
        else if (sw_clr)   pll_event_flag_q <= 1'b0;                          // [RQ4] [RQ5]
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_crystal_ref_clock       = xclk_q;
    assign o_base_clock_out          = base_q;
    assign o_clock_gen_irq           = run & pll_event_flag_q & pie_q & auto_q; // [RQ1]
    assign o_base_src_select         = bcs_q;
    assign o_pll_irq_enable          = pie_q;
    assign o_pll_event_flag          = pll_event_flag_q & auto_q;             // [RQ10]
    assign o_auto_bw                 = auto_q;
    assign o_acq_tracking_status     = auto_q ? acq_st_q : acq_man_q; // [RQ12]
    assign o_lock                    = lock_q & auto_q;             // [RQ11]
    assign o_break_clear_flag_enable = break_clear_flag_enable_q;

endmodule // pcsb_top

// file: pcsb_monitor.sv
// pcsb_monitor.sv: concurrent checks on the stop and break control ports.
// assumes: bound onto pcsb_top; one clock, async active-low reset.
`timescale 1ns/1ps
module pcsb_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // watched inputs
    input wire logic i_osc_enable_from_sysctl,
    input wire logic i_break_active,
    input wire logic i_break_clear_flag_enable_wr,
    input wire logic i_pll_control_reg_wr,
    input wire logic i_base_src_select_wr,
    input wire logic i_pll_event_flag_clr,
    input wire logic i_pll_bandwidth_reg_wr,
    input wire logic i_auto_bw_wr,
    input wire logic i_acq_tracking_wr,
    input wire logic i_err_below_track,
    input wire logic i_err_below_lock,
    // watched outputs
    input wire logic o_crystal_ref_clock,
    input wire logic o_base_clock_out,
    input wire logic o_clock_gen_irq,
    input wire logic o_base_src_select,
    input wire logic o_pll_irq_enable,
    input wire logic o_pll_event_flag,
    input wire logic o_auto_bw,
    input wire logic o_acq_tracking_status,
    input wire logic o_lock,
    input wire logic o_break_clear_flag_enable
);
    // ****************************************************************
    // checks: five samples cover the two-stage enable sync plus update
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_stop_outs_low: assert property (!i_osc_enable_from_sysctl [*5] |->
        !o_crystal_ref_clock && !o_base_clock_out && !o_clock_gen_irq) else $error("clock out in stop");
    a_stop_src_clear: assert property (!i_osc_enable_from_sysctl [*5] |->
        !o_base_src_select) else $error("source select kept in stop");
    a_src_by_sw: assert property ($rose(o_base_src_select) |->
        $past(i_pll_control_reg_wr && i_base_src_select_wr)) else $error("source select set alone");
    a_break_keeps_flag: assert property (i_break_active && !o_break_clear_flag_enable &&
        o_pll_event_flag && !i_pll_bandwidth_reg_wr && !i_break_clear_flag_enable_wr
        |=> o_pll_event_flag) else $error("flag lost in protected break");
    a_break_clear_ok: assert property ((i_break_active && o_break_clear_flag_enable &&
        !i_break_clear_flag_enable_wr && !i_pll_bandwidth_reg_wr && i_pll_event_flag_clr
        ##1 $stable(o_lock)) |-> !o_pll_event_flag) else $error("break clear ignored");
    a_flag_from_lock: assert property ($rose(o_pll_event_flag) && $stable(o_auto_bw) |->
        $changed(o_lock)) else $error("flag set without lock change");
    a_lock_sets_flag: assert property ($changed(o_lock) && $stable(o_auto_bw) |->
        o_pll_event_flag) else $error("lock change without flag");
    a_manual_zero: assert property (!o_auto_bw |->
        !o_lock && !o_pll_event_flag && !o_clock_gen_irq) else $error("manual mode shows lock");
    a_lock_entry: assert property ((o_auto_bw && i_err_below_lock) [*5] |->
        o_lock) else $error("lock not reached");
    a_track_entry: assert property ((o_auto_bw && i_err_below_track) [*5] |->
        o_acq_tracking_status) else $error("tracking not reached");
    a_manual_track: assert property (!o_auto_bw && i_pll_bandwidth_reg_wr && !i_auto_bw_wr
        |=> o_acq_tracking_status == $past(i_acq_tracking_wr)) else $error("manual track lost");
    a_irq_gated: assert property (o_clock_gen_irq |->
        o_pll_irq_enable && o_pll_event_flag) else $error("irq without enable");
    // main scenarios reached
    cover property ($rose(o_lock));
    cover property (i_break_active && o_break_clear_flag_enable && i_pll_event_flag_clr);
    cover property ($fell(o_base_src_select));
endmodule // pcsb_monitor

// file: pcsb_pll_model.sv
// pcsb_pll_model.sv: oscillator, vco and comparator side facing the block.
// assumes: same clock as the block; requests from the bench steer the error levels.
`timescale 1ns/1ps
module pcsb_pll_model #(
    parameter int XT_PER = 2                 // cycles per crystal tick
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // steering
    input  wire logic i_run,
    input  wire logic i_lock_req,
    input  wire logic i_track_req,
    // towards the block
    output logic      o_xtal_tick,
    output logic      o_vco_tick,
    output logic      o_err_below_track,
    output logic      o_err_below_lock
);
    logic [3:0] cnt_q;                       // crystal tick spacing
    // ticks stand still while the oscillator is off, as a real one would
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= (cnt_q == 4'(XT_PER - 1)) ? 4'h0 : cnt_q + 4'h1;
        end
    end
    assign o_xtal_tick = i_run && (cnt_q == 4'h0);
    assign o_vco_tick  = i_run;              // vco twice as fast as crystal
    // lock tolerance is tighter, so lock implies tracking
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_err_below_track <= 1'b0;
            o_err_below_lock  <= 1'b0;
        end else begin
            o_err_below_track <= i_track_req || i_lock_req;
            o_err_below_lock  <= i_lock_req;
        end
    end
endmodule // pcsb_pll_model

// file: tb_pcsb_top.sv
// tb_pcsb_top.sv: self-checking bench for the stop and break control block.
// assumes: pcsb_pkg compiled first; 200 MHz clock; monitor bound below.
`timescale 1ns/1ps
module tb_pcsb_top;
    import pcsb_pkg::*;
    localparam int XT_PER = 2;               // crystal tick spacing in the model
    logic clk, rst_n, osc, brk, break_clear_flag_enable_wr, break_clear_flag_enable_val, rd, wr, src, ie, clr, bw_wr, auto, acq_tracking_status;
    logic lock_req, track_req, xt, vt, etr, elk, ie_bit;
    logic crys, base, irq, s_src, s_ie, s_flag, s_auto, s_acq, s_lock, s_break_clear_flag_enable;
    int   err_count, samples_checked, seed, i, n;
    // ****************************************************************
    // clock, design and far side
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    pcsb_top u_pcsb_top (.i_clk(clk), .i_rst_n(rst_n), .i_osc_enable_from_sysctl(osc),
        .i_break_active(brk), .i_break_clear_flag_enable_wr(break_clear_flag_enable_wr),
        .i_break_clear_flag_enable_val(break_clear_flag_enable_val), .i_pll_control_reg_rd(rd),
        .i_pll_control_reg_wr(wr), .i_base_src_select_wr(src), .i_pll_irq_enable_wr(ie),
        .i_pll_event_flag_clr(clr), .i_pll_bandwidth_reg_wr(bw_wr), .i_auto_bw_wr(auto),
        .i_acq_tracking_wr(acq_tracking_status), .i_xtal_tick(xt), .i_vco_tick(vt), .i_err_below_track(etr),
        .i_err_below_lock(elk), .o_crystal_ref_clock(crys), .o_base_clock_out(base),
        .o_clock_gen_irq(irq), .o_base_src_select(s_src), .o_pll_irq_enable(s_ie),
        .o_pll_event_flag(s_flag), .o_auto_bw(s_auto), .o_acq_tracking_status(s_acq),
        .o_lock(s_lock), .o_break_clear_flag_enable(s_break_clear_flag_enable));
    pcsb_pll_model #(.XT_PER(XT_PER)) u_pcsb_pll_model (.i_clk(clk), .i_rst_n(rst_n),
        .i_run(osc), .i_lock_req(lock_req), .i_track_req(track_req), .o_xtal_tick(xt),
        .o_vco_tick(vt), .o_err_below_track(etr), .o_err_below_lock(elk));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic exp_irq(logic a, logic f, logic e);
        return a & f & e;                    // irq needs auto, flag and enable
    endfunction
    function automatic logic exp_acq(logic a, logic trk, logic man);
        return a ? trk : man;                // auto shows comparator, manual the bit
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // k: 0 control write, 1 bandwidth write, 2 break enable load, 3 clear, 4 read
    task automatic pulse(input int k, input logic a, input logic b);
        @(posedge clk);
        {wr, bw_wr, break_clear_flag_enable_wr, clr, rd} <= 5'h10 >> k;
        {src, auto, break_clear_flag_enable_val} <= {3{a}};
        {ie, acq_tracking_status} <= {2{b}};
        @(posedge clk);
        {wr, bw_wr, break_clear_flag_enable_wr, clr, rd} <= 5'h00;
        @(negedge clk);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    // rising edges of the base clock over len settled samples
    task automatic count_base(input int len, output int c);
        logic p;
        c = 0;
        p = base;
        repeat (len) begin
            @(negedge clk);
            c += int'(base && !p);
            p = base;
        end
    endtask
    task automatic rst_check;
        @(negedge clk);
        chk({crys, base, irq, s_src, s_ie, s_flag, s_auto, s_acq, s_lock, s_break_clear_flag_enable}, {3'h0,
            RST_BASE_SRC, 1'b0, RST_EVENT_FLAG, RST_AUTO_BW, RST_ACQ, RST_LOCK, RST_BREAK_CLEAR_FLAG_ENABLE});
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 4000 cycles
    initial begin
        #(5 * 4000);
        err_count++;
        $display("BAD t=%0t run hung", $time);
        end_of_test();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'h8501;
        {osc, brk, break_clear_flag_enable_wr, break_clear_flag_enable_val, rd, wr, src, ie, clr, bw_wr, auto, acq_tracking_status} = 12'h800;
        {lock_req, track_req, rst_n, err_count, samples_checked} = '0;
        repeat (5) @(posedge clk);
        rst_check();
        @(posedge clk);
        rst_n <= 1'b1;
        // stop with the vco path selected, then restart
        wait_cyc(8);
        pulse(0, SRC_VCO_HALF, 1'b0);
        chk(s_src, SRC_VCO_HALF);
        count_base(16, n);
        chk(n >= 16 / (HALF_DIV * 2) - 1 && n <= 16 / (HALF_DIV * 2) + 1, 1'b1);
        @(posedge clk);
        osc <= 1'b0;
        wait_cyc(6);
        chk({crys, base, irq}, 3'h0);
        chk(s_src, SRC_XTAL_HALF);
        @(posedge clk);
        osc <= 1'b1;
        for (n = 0; n < 20 && crys !== 1'b1; n++) @(negedge clk);
        chk(crys, 1'b1);
        chk(base, 1'b0);
        count_base(32, n);
        chk(n >= 32 / (XT_PER * 4) - 1 && n <= 32 / (XT_PER * 4) + 1, 1'b1);
        chk(s_src, SRC_XTAL_HALF);
        $display("test stop done");
        // automatic mode, lock entry, irq and break protection
        pulse(1, 1'b1, 1'b0);
        lock_req <= 1'b1;
        wait_cyc(8);
        chk({s_lock, s_flag, s_acq}, 3'h7);
        ie_bit = 1'($random(seed));
        pulse(0, 1'b0, ie_bit);
        chk(s_ie, ie_bit);
        chk(irq, exp_irq(1'b1, 1'b1, ie_bit));
        @(posedge clk);
        brk <= 1'b1;
        pulse(3, 1'b0, 1'b0);
        pulse(4, 1'b0, 1'b0);
        chk(s_flag, 1'b1);
        pulse(2, 1'b1, 1'b0);
        pulse(3, 1'b0, 1'b0);
        chk(s_flag, 1'b0);
        @(posedge clk);
        brk <= 1'b0;
        wait_cyc(3);
        chk(s_flag, 1'b0);
        lock_req <= 1'b0;
        wait_cyc(8);
        chk({s_lock, s_flag}, 2'h1);
        $display("test break done");
        // manual tracking bit both ways, then auto ignores it
        for (i = 0; i < 2; i++) begin
            pulse(1, 1'b0, 1'(i));
            chk({s_acq, s_lock, s_flag}, {exp_acq(1'b0, 1'b0, 1'(i)), 2'h0});
        end
        pulse(1, 1'b1, 1'b1);
        wait_cyc(4);
        chk(s_acq, exp_acq(1'b1, etr, 1'b1));
        $display("test manual done");
        // random traffic; the monitor judges every cycle
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            {wr, bw_wr, break_clear_flag_enable_wr, clr, rd, src, ie, auto, acq_tracking_status, break_clear_flag_enable_val} <= 10'($random(seed));
            osc <= (($random(seed) & 15) != 0);
            if (($random(seed) & 7) == 0) begin
                {brk, lock_req, track_req} <= 3'($random(seed));
            end
        end
        @(posedge clk);
        {wr, bw_wr, break_clear_flag_enable_wr, clr, rd} <= 5'h00;
        $display("test random done");
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        wait_cyc(2);
        rst_check();
        @(posedge clk);
        rst_n <= 1'b1;
        osc <= 1'b1;
        wait_cyc(2);
        chk({crys, base, irq, s_src}, 4'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule // tb_pcsb_top

bind pcsb_top pcsb_monitor u_pcsb_monitor (.*);
